// [design/pch_regs.sv]
// pch_regs: part of the pci configuration header held by the pci
// controller: command low bits, class code/revision, and the
// selftest/header type/latency/cacheline word.
// assumes: one clock; requests from the pci configuration decoder and
// the internal peripheral bus are synchronous and last one cycle.
`timescale 1ns/1ns
`default_nettype none
`include "pch_map.svh"

module pch_regs #(
    // arbitrary neutral value, stands for the silicon version
    parameter logic [7:0] REVISION_ID = `PCH_REVISION_DFLT
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic soft_rst_in,
    input wire logic config_init_done_in,
    input wire pch_pkg::pch_req_t cfg_req_in,
    output pch_pkg::pch_rsp_t cfg_rsp_out,
    input wire pch_pkg::pch_req_t ppb_req_in,
    output pch_pkg::pch_rsp_t ppb_rsp_out,
    input wire logic tgt_mem_hit_in,
    input wire logic tgt_io_hit_in,
    output logic tgt_claim_out,
    input wire logic mst_req_in,
    output logic mst_start_out,
    output logic [3:0] mst_cmd_out,
    output logic master_enable_out,
    output logic mem_space_enable_out,
    output logic io_space_enable_out,
    output logic [7:0] latency_timer_field_out,
    output logic [7:0] base_class_field_out,
    output logic [7:0] sub_class_field_out,
    output logic [7:0] prog_interface_field_out
);

    ////////////////////////////////////////////////////////////////////
    // storage

    logic [`PCH_CMD_W-1:0] cmd_reg;
    logic [`PCH_CLASS_MSB:`PCH_CLASS_LSB] class_reg;
    logic [`PCH_LAT_MSB:`PCH_LAT_LSB] lat_reg;

    logic master_en;
    logic mem_en;
    logic io_en;

    assign master_en = cmd_reg[`PCH_BIT_MASTER_EN];
    assign mem_en = cmd_reg[`PCH_BIT_MEM_SPACE_EN];
    assign io_en = cmd_reg[`PCH_BIT_IO_SPACE_EN];

    ////////////////////////////////////////////////////////////////////
    // helpers

    // byte-lane merge, then keep only bits this port may change
    function automatic logic [31:0] pch_merge(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] be,
        input logic [31:0] wmask
    );
        logic [31:0] lanes;
        lanes = old_word;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                lanes[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return (old_word & ~wmask) | (lanes & wmask);
    endfunction : pch_merge

    logic [31:0] cmd_word;
    logic [31:0] class_word;
    logic [31:0] hdr_word;

    // upper command/status bits belong elsewhere and read zero here
    assign cmd_word = {26'h000_0000, `PCH_CMD_FIXED, cmd_reg};
    assign class_word = {class_reg, REVISION_ID};
    assign hdr_word = {`PCH_SELFTEST_FIXED, `PCH_HEADER_TYPE_FIXED,
                       lat_reg, `PCH_CACHELINE_FIXED};

    function automatic logic [31:0] pch_read(input logic [7:0] addr);
        logic [31:0] word;
        case (addr)
            `PCH_OFS_CMD: word = cmd_word;
            `PCH_OFS_CLASS: word = class_word;
            `PCH_OFS_HDR: word = hdr_word;
            default: word = `PCH_ZERO_WORD;
        endcase
        return word;
    endfunction : pch_read

    ////////////////////////////////////////////////////////////////////
    // access decode

    // pci config cycles are retried until software opens config access,
    // so the class code cannot be seen half-programmed
    logic cfg_go;
    logic cfg_wr;
    logic ppb_wr;

    assign cfg_go = cfg_req_in.valid & config_init_done_in;
    assign cfg_wr = cfg_go & cfg_req_in.write;
    assign ppb_wr = ppb_req_in.valid & ppb_req_in.write;

    logic cfg_wr_cmd;
    logic ppb_wr_cmd;
    logic cfg_wr_hdr;
    logic ppb_wr_hdr;
    logic ppb_wr_class;

    assign cfg_wr_cmd = cfg_wr & (cfg_req_in.addr == `PCH_OFS_CMD);
    assign ppb_wr_cmd = ppb_wr & (ppb_req_in.addr == `PCH_OFS_CMD);
    assign cfg_wr_hdr = cfg_wr & (cfg_req_in.addr == `PCH_OFS_HDR);
    assign ppb_wr_hdr = ppb_wr & (ppb_req_in.addr == `PCH_OFS_HDR);
    assign ppb_wr_class = ppb_wr & (ppb_req_in.addr == `PCH_OFS_CLASS);

    logic [31:0] cfg_cmd_next;
    logic [31:0] ppb_cmd_next;
    logic [31:0] cfg_hdr_next;
    logic [31:0] ppb_hdr_next;
    logic [31:0] class_next;

    assign cfg_cmd_next = pch_merge(cmd_word, cfg_req_in.wdata,
                                    cfg_req_in.be, `PCH_CMD_WMASK);
    assign ppb_cmd_next = pch_merge(cmd_word, ppb_req_in.wdata,
                                    ppb_req_in.be, `PCH_CMD_WMASK);
    assign cfg_hdr_next = pch_merge(hdr_word, cfg_req_in.wdata,
                                    cfg_req_in.be, `PCH_HDR_WMASK);
    assign ppb_hdr_next = pch_merge(hdr_word, ppb_req_in.wdata,
                                    ppb_req_in.be, `PCH_HDR_WMASK);
    assign class_next = pch_merge(class_word, ppb_req_in.wdata,
                                  ppb_req_in.be, `PCH_CLASS_WMASK);

    ////////////////////////////////////////////////////////////////////
    // command low bits; pci wins a same-cycle collision

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_reg <= `PCH_CMD_RST;
        end else if (soft_rst_in) begin
            cmd_reg <= `PCH_CMD_RST;
        end else if (cfg_wr_cmd) begin
            cmd_reg <= cfg_cmd_next[`PCH_CMD_W-1:0];
        end else if (ppb_wr_cmd) begin
            cmd_reg <= ppb_cmd_next[`PCH_CMD_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // latency timer, the only writable byte of the header word

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lat_reg <= `PCH_LAT_RST;
        end else if (soft_rst_in) begin
            lat_reg <= `PCH_LAT_RST;
        end else if (cfg_wr_hdr) begin
            lat_reg <= cfg_hdr_next[`PCH_LAT_MSB:`PCH_LAT_LSB];
        end else if (ppb_wr_hdr) begin
            lat_reg <= ppb_hdr_next[`PCH_LAT_MSB:`PCH_LAT_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // class code: no reset at all, internal bus is the only writer;
    // it reads unknown until software programs it

    always_ff @(posedge clk_sys_in) begin
        if (ppb_wr_class) begin
            class_reg <= class_next[`PCH_CLASS_MSB:`PCH_CLASS_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, zero for writes and refused accesses

    logic [31:0] cfg_rdata_next;
    logic [31:0] ppb_rdata_next;

    always_comb begin
        cfg_rdata_next = `PCH_ZERO_WORD;
        if (cfg_go && !cfg_req_in.write) begin
            cfg_rdata_next = pch_read(cfg_req_in.addr);
        end
    end

    always_comb begin
        ppb_rdata_next = `PCH_ZERO_WORD;
        if (ppb_req_in.valid && !ppb_req_in.write) begin
            ppb_rdata_next = pch_read(ppb_req_in.addr);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // answers, one cycle after each request

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_rsp_out <= '0;
        end else begin
            cfg_rsp_out.ack <= cfg_req_in.valid;
            cfg_rsp_out.retry <= cfg_req_in.valid & ~config_init_done_in;
            cfg_rsp_out.rdata <= cfg_rdata_next;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ppb_rsp_out <= '0;
        end else begin
            ppb_rsp_out.ack <= ppb_req_in.valid;
            ppb_rsp_out.retry <= 1'b0;
            ppb_rsp_out.rdata <= ppb_rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // target claim and master start gating

    // special cycles are never decoded as a hit, so they go unclaimed
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tgt_claim_out <= 1'b0;
        end else begin
            tgt_claim_out <= (tgt_mem_hit_in & mem_en)
                           | (tgt_io_hit_in & io_en);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mst_start_out <= 1'b0;
        end else begin
            mst_start_out <= mst_req_in & master_en;
        end
    end

    // the command never varies: write-and-invalidate is not offered
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mst_cmd_out <= `PCH_PCI_CMD_MEMWR;
        end else begin
            mst_cmd_out <= `PCH_PCI_CMD_MEMWR;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered copies of the controls for the rest of the controller

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            master_enable_out <= 1'b0;
            mem_space_enable_out <= 1'b0;
            io_space_enable_out <= 1'b0;
        end else begin
            master_enable_out <= master_en;
            mem_space_enable_out <= mem_en;
            io_space_enable_out <= io_en;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            latency_timer_field_out <= `PCH_LAT_RST;
        end else begin
            latency_timer_field_out <= lat_reg;
        end
    end

    logic [7:0] base_class;
    logic [7:0] sub_class;
    logic [7:0] prog_interface;

    assign base_class = class_reg[`PCH_BASE_MSB:`PCH_BASE_LSB];
    assign sub_class = class_reg[`PCH_SUB_MSB:`PCH_SUB_LSB];
    assign prog_interface = class_reg[`PCH_PROG_MSB:`PCH_PROG_LSB];

    // no reset: follows the unreset class code
    always_ff @(posedge clk_sys_in) begin
        base_class_field_out <= base_class;
        sub_class_field_out <= sub_class;
        prog_interface_field_out <= prog_interface;
    end

endmodule : pch_regs
`default_nettype wire

// [include/pch_map.svh]
// pch_map.svh: offsets, field positions, masks and reset values of the
// configuration header registers.
// assumes: included by its bare name from the package and the design.
`ifndef PCH_MAP_SVH
`define PCH_MAP_SVH

// register offsets, same on the pci and internal sides
`define PCH_OFS_CMD 8'h04
`define PCH_OFS_CLASS 8'h08
`define PCH_OFS_HDR 8'h0C

// command word fields
`define PCH_BIT_IO_SPACE_EN 0
`define PCH_BIT_MEM_SPACE_EN 1
`define PCH_BIT_MASTER_EN 2
`define PCH_CMD_W 3
`define PCH_CMD_WMASK 32'h0000_0007
`define PCH_CMD_RST 3'h0
// palette snoop, write-invalidate and special cycle read back as zero
`define PCH_CMD_FIXED 3'h0

// class/revision word fields
`define PCH_CLASS_LSB 8
`define PCH_CLASS_MSB 31
`define PCH_CLASS_WMASK 32'hFFFF_FF00
`define PCH_BASE_MSB 31
`define PCH_BASE_LSB 24
`define PCH_SUB_MSB 23
`define PCH_SUB_LSB 16
`define PCH_PROG_MSB 15
`define PCH_PROG_LSB 8
`define PCH_REVISION_DFLT 8'h00

// selftest/header/latency/cacheline word fields
`define PCH_LAT_LSB 8
`define PCH_LAT_MSB 15
`define PCH_HDR_WMASK 32'h0000_FF00
`define PCH_LAT_RST 8'h00
`define PCH_SELFTEST_FIXED 8'h00
`define PCH_HEADER_TYPE_FIXED 8'h00
`define PCH_CACHELINE_FIXED 8'h00

// pci bus command issued for master writes
`define PCH_PCI_CMD_MEMWR 4'h7
`define PCH_ZERO_WORD 32'h0000_0000

`endif

// [include/pch_pkg.sv]
// pch_pkg: request and answer carriers of the two register access ports.
// assumes: pch_map.svh is on the include path.
`include "pch_map.svh"

package pch_pkg;

    // one register access, held for one cycle with valid high
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pch_req_t;

    // answer one cycle after the request
    typedef struct packed {
        logic ack;
        logic retry;
        logic [31:0] rdata;
    } pch_rsp_t;

endpackage : pch_pkg

// [tb/pch_host.sv]
// pch_host: pci or internal side requester issuing single configuration accesses.
// assumes: the answer arrives one cycle after the request is taken.
`timescale 1ns/1ns
`default_nettype none
module pch_host (
    input wire logic clk_sys_in,
    input wire pch_pkg::pch_rsp_t rsp_in,
    output pch_pkg::pch_req_t req_out
);
    initial req_out = '0;
    // released lines turn over so a stale value is never mistaken for a live one
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                        output pch_pkg::pch_rsp_t r);
        @(negedge clk_sys_in);
        req_out = '{1'b1, w, a, be, d};
        // the answer stands for one cycle only, so it is taken as the request drops
        @(negedge clk_sys_in);
        r = rsp_in;
        req_out = '{1'b0, ~w, ~a, ~be, ~d};
    endtask : xfer
endmodule : pch_host
`default_nettype wire

// [tb/pch_regs_monitor.sv]
// pch_regs_chk: port-level checks of the configuration header block.
// assumes: bound into pch_regs; one clock, reset active low.
`timescale 1ns/1ns
`default_nettype none
module pch_regs_chk #(
    parameter logic [7:0] REVISION_ID = 8'h00
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic soft_rst_in,
    input wire logic config_init_done_in,
    input wire pch_pkg::pch_req_t cfg_req_in,
    input wire pch_pkg::pch_rsp_t cfg_rsp_out,
    input wire pch_pkg::pch_req_t ppb_req_in,
    input wire pch_pkg::pch_rsp_t ppb_rsp_out,
    input wire logic tgt_claim_out,
    input wire logic mst_start_out,
    input wire logic [3:0] mst_cmd_out,
    input wire logic mst_req_in,
    input wire logic tgt_mem_hit_in,
    input wire logic tgt_io_hit_in,
    input wire logic master_enable_out,
    input wire logic mem_space_enable_out,
    input wire logic io_space_enable_out,
    input wire logic [7:0] latency_timer_field_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////////
    chk_closed_retry: assert property (cfg_req_in.valid && !config_init_done_in
        |=> cfg_rsp_out.retry && cfg_rsp_out.rdata == '0) else $error("cfg not refused");
    chk_cmd_fixed: assert property (ppb_req_in.valid && !ppb_req_in.write && ppb_req_in.addr == 8'h04
        |=> ppb_rsp_out.ack && ppb_rsp_out.rdata[31:3] == '0) else $error("cmd fixed bits");
    chk_rev_fixed: assert property (ppb_req_in.valid && !ppb_req_in.write && ppb_req_in.addr == 8'h08
        |=> ppb_rsp_out.rdata[7:0] == REVISION_ID) else $error("revision");
    chk_hdr_fixed: assert property (ppb_req_in.valid && !ppb_req_in.write && ppb_req_in.addr == 8'h0C
        |=> ppb_rsp_out.rdata[31:16] == '0 && ppb_rsp_out.rdata[7:0] == '0) else $error("hdr fixed bits");
    chk_memwr_only: assert property (mst_cmd_out == 4'h7) else $error("master cmd");
    chk_master_gate: assert property (mst_start_out == ($past(mst_req_in) && master_enable_out))
        else $error("start without enable");
    chk_claim_gate: assert property (tgt_claim_out == (($past(tgt_mem_hit_in) && mem_space_enable_out)
        || ($past(tgt_io_hit_in) && io_space_enable_out))) else $error("claim without enable");
    chk_soft_clear: assert property (soft_rst_in && !ppb_req_in.valid ##1 !ppb_req_in.valid && !cfg_req_in.valid
        |=> !master_enable_out && !mem_space_enable_out && !io_space_enable_out && latency_timer_field_out == '0)
        else $error("soft reset");
    cover property (tgt_claim_out);
    cover property (mst_start_out);
    cover property (cfg_rsp_out.retry);
endmodule : pch_regs_chk
bind pch_regs pch_regs_chk #(.REVISION_ID(REVISION_ID)) u_chk (.clk_sys_in, .rstn_in, .soft_rst_in,
    .config_init_done_in, .cfg_req_in, .cfg_rsp_out, .ppb_req_in, .ppb_rsp_out, .tgt_claim_out, .mst_start_out,
    .mst_cmd_out, .mst_req_in, .tgt_mem_hit_in, .tgt_io_hit_in, .master_enable_out, .mem_space_enable_out,
    .io_space_enable_out, .latency_timer_field_out);
`default_nettype wire

// [tb/testbench.sv]
// testbench: register model of the header block checked at every answer.
// assumes: pch_regs with the pci side driven by pch_host.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] REV = 8'h5A; // arbitrary silicon version
    logic clk_sys_in = 0, rstn_in = 0, soft_rst_in = 0, init_done = 0, mem_hit = 0, io_hit = 0, mst_req = 0;
    logic claim, start, me, mse, ise;
    logic [3:0] mcmd;
    logic [7:0] lat_o, bc, sc, pi;
    pch_pkg::pch_req_t cfg_req, ppb_req;
    pch_pkg::pch_rsp_t cfg_rsp, ppb_rsp, r;
    int num_errors = 0, total_checks = 0, cycles = 0;
    logic [2:0] cmd_m = 0;
    logic [23:0] cls_m = 0;
    logic [7:0] lat_m = 0;
    logic [31:0] lf = 32'h1F57;
    logic [7:0] bases [4] = '{8'h00, 8'h06, 8'h0C, 8'hFF};
    ////////////////////////////////////////////////////////////////////////
    pch_regs #(.REVISION_ID(REV)) u_dut (.clk_sys_in, .rstn_in, .soft_rst_in, .config_init_done_in(init_done),
        .cfg_req_in(cfg_req), .cfg_rsp_out(cfg_rsp), .ppb_req_in(ppb_req), .ppb_rsp_out(ppb_rsp),
        .tgt_mem_hit_in(mem_hit), .tgt_io_hit_in(io_hit), .tgt_claim_out(claim), .mst_req_in(mst_req),
        .mst_start_out(start), .mst_cmd_out(mcmd), .master_enable_out(me), .mem_space_enable_out(mse),
        .io_space_enable_out(ise), .latency_timer_field_out(lat_o), .base_class_field_out(bc),
        .sub_class_field_out(sc), .prog_interface_field_out(pi));
    pch_host u_host (.clk_sys_in, .rsp_in(cfg_rsp), .req_out(cfg_req));
    pch_host u_ppb (.clk_sys_in, .rsp_in(ppb_rsp), .req_out(ppb_req));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h04: return {29'h0, cmd_m};
            8'h08: return {cls_m, REV};
            8'h0C: return {16'h0, lat_m, 8'h00};
            default: return 32'h0;
        endcase
    endfunction : exp_rd
    task automatic acc(input logic pci, input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic ok;
        ok = !pci || init_done;
        if (pci) u_host.xfer(w, a, be, d, r);
        else u_ppb.xfer(w, a, be, d, r);
        chk("ack", r.ack, 1);
        chk("retry", r.retry, pci && !init_done);
        chk("rdata", r.rdata, (w || !ok) ? 32'h0 : exp_rd(a));
        if (w && ok) begin
            if (a == 8'h04 && be[0]) cmd_m = d[2:0];
            if (a == 8'h0C && be[1]) lat_m = d[15:8];
            if (a == 8'h08 && !pci) for (int i = 1; i < 4; i++) if (be[i]) cls_m[i*8-8 +: 8] = d[i*8 +: 8];
        end
    endtask : acc
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk_sys_in);
        rstn_in = 1;
        acc(1, 1, 8'h04, 4'hF, 32'h7);
        acc(0, 0, 8'h0C, 4'hF, 0);
        // class set while the pci side is still closed
        foreach (bases[i]) begin
            acc(0, 1, 8'h08, 4'hF, {bases[i], 16'h1234, 8'hFF} ^ i);
            acc(0, 0, 8'h08, 4'hF, 0);
            chk("class", {bc, sc, pi}, cls_m);
        end
        for (int v = 0; v < 8; v++) begin
            acc(0, 1, 8'h04, 4'h1, {29'h0, v[2:0]} ^ 32'hFFFF_FFF8);
            @(negedge clk_sys_in);
            chk("enables", {me, mse, ise}, v);
            for (int h = 0; h < 8; h++) begin
                {mst_req, mem_hit, io_hit} = h[2:0];
                @(negedge clk_sys_in);
                chk("claim", claim, (h[1] & v[1]) | (h[0] & v[0]));
                chk("start", start, h[2] & v[2]);
                chk("mcmd", mcmd, 4'h7);
            end
            {mst_req, mem_hit, io_hit} = 3'b000;
        end
        init_done = 1;
        acc(1, 1, 8'h08, 4'hF, 32'hFFFF_FFFF);
        repeat (40) begin
            lf = lfsr(lf);
            acc(lf[0], lf[1], {3'b000, 3'(lf[3:2]) + 3'd1, 2'b00}, lf[7:4], {8'h06, lf[31:8]});
        end
        @(negedge clk_sys_in);
        chk("lat_out", lat_o, lat_m);
        acc(1, 1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
        acc(1, 0, 8'h0C, 4'hF, 0);
        @(negedge clk_sys_in);
        soft_rst_in = 1;
        @(negedge clk_sys_in);
        soft_rst_in = 0;
        cmd_m = 0;
        lat_m = 0;
        for (int a = 4; a < 20; a += 4) acc(0, 0, a[7:0], 4'hF, 0);
        // power-on reset in mid-run: controls clear, class code survives
        acc(0, 1, 8'h04, 4'h1, 32'h7);
        acc(0, 1, 8'h0C, 4'h2, 32'h0000_3C00);
        rstn_in = 0;
        repeat (2) @(negedge clk_sys_in);
        rstn_in = 1;
        cmd_m = 0;
        lat_m = 0;
        for (int a = 4; a < 16; a += 4) acc(1, 0, a[7:0], 4'hF, 0);
        chk("class_kept", {bc, sc, pi}, cls_m);
        chk("lat_rst", lat_o, lat_m);
        chk("enables_rst", {me, mse, ise}, cmd_m);
        summarize();
    end
endmodule : testbench
`default_nettype wire
